// ==== src/imx_core.sv ====
/*
 * Interrupt mask, status flags, primary transceiver control and doze state.
 * Registers are reached over the serial register port. Assumes the event
 * inputs, wake and start pins are synchronous one-cycle pulses or levels in
 * the i_mclk domain.
 * Every enable is a plain AND term, so a source left disabled in one
 * register cannot be switched on through the other.
 */
`timescale 1ns/1ps
`default_nettype none
module imx_core (
	input  wire logic              i_mclk,
	input  wire logic              i_sys_rst,
	input  wire logic              i_spi_ce_n,
	input  wire logic              i_spi_clk,
	input  wire logic              i_spi_mosi,
	output logic                   o_spi_miso,
	output logic                   o_spi_miso_oe_n,
	input  wire imx_pkg::imx_evt_t i_evt,
	input  wire logic              i_doze_req,
	input  wire logic              i_wake_n,
	input  wire logic              i_tc2_match,
	input  wire logic              i_tc2p_match,
	input  wire logic              i_seq_start_pin,
	output logic                   o_irq_n,
	output logic                   o_dozing,
	output logic                   o_tmr_clk_en,
	output logic                   o_tx_stream,
	output logic                   o_rx_stream,
	output logic [1:0]             o_cca_type,
	output logic [1:0]             o_xcvr_seq,
	output logic                   o_seq_go
);
	imx_pkg::imx_req_t req;
	logic [15:0]       rd_data;
	logic [15:0]       mask_q;
	logic [15:0]       ctrl_q;
	logic [15:0]       flag_q;
	logic [15:0]       flag_d;
	logic [15:0]       enable;
	logic [15:0]       evt_vec;
	logic              status_rd;
	logic              start_pin_q;
	logic              deep;
	imx_pkg::imx_doze_t doze_q;

	// Frame handling lives in the serial port.
	imx_spi_port u_port (
		.i_mclk      (i_mclk),
		.i_sys_rst   (i_sys_rst),
		.i_spi_ce_n  (i_spi_ce_n),
		.i_spi_clk   (i_spi_clk),
		.i_spi_mosi  (i_spi_mosi),
		.i_rd_data   (rd_data),
		.o_req       (req),
		.o_miso      (o_spi_miso),
		.o_miso_oe_n (o_spi_miso_oe_n)
	);

	// Writable bits only; reserved bits keep their zero default.
	// Masking here spares every reader from filtering reserved positions.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			mask_q <= imx_pkg::MASK_RST;
		else if (req.wr && req.addr == imx_pkg::ADDR_MASK)
			mask_q <= req.wdata & imx_pkg::MASK_WMSK;
	end

	// The control word steers streaming, triggering and the sequence.
	// Reset leaves the sequence idle so nothing starts before the host programs it.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			ctrl_q <= imx_pkg::CTRL_RST;
		else if (req.wr && req.addr == imx_pkg::ADDR_CTRL)
			ctrl_q <= req.wdata & imx_pkg::CTRL_WMSK;
	end

	// Register read mux; unmapped addresses read as zero.
	// The address is held from the header on, so the word is stable as it loads.
	always_comb begin
		rd_data = 16'h0000;
		unique case (req.addr)
			imx_pkg::ADDR_MASK:   rd_data = mask_q;
			imx_pkg::ADDR_CTRL:   rd_data = ctrl_q;
			imx_pkg::ADDR_STATUS: rd_data = flag_q;
			default:              rd_data = 16'h0000;
		endcase
	end

	// Enables gathered into status bit order from both registers.
	// Status bits 7 to 5 have no enable and can never reach the pin.
	always_comb begin
		enable                = 16'h0000;
		enable[15]            = mask_q[imx_pkg::MASK_ATTN];
		enable[14]            = ctrl_q[imx_pkg::CTRL_CCA];
		enable[13]            = ctrl_q[imx_pkg::CTRL_TXSENT];
		enable[12]            = mask_q[imx_pkg::MASK_RAMAD];
		enable[11]            = mask_q[imx_pkg::MASK_ARB];
		enable[10]            = mask_q[imx_pkg::MASK_STRM];
		enable[9]             = mask_q[imx_pkg::MASK_PLL];
		enable[8]             = ctrl_q[imx_pkg::CTRL_RXRCVD];
		enable[4]             = mask_q[imx_pkg::MASK_DOZE];
		enable[3:0]           = mask_q[3:0];
	end

	assign evt_vec   = i_evt & 16'hFF1F;
	assign status_rd = req.rd && req.addr == imx_pkg::ADDR_STATUS;

	// Flags set regardless of their enable; an event in the clearing cycle wins.
	// Losing an event costs more than one extra status read, hence the priority.
	generate
		for (genvar b = 0; b < 16; b++) begin : g_flag
			always_comb begin
				flag_d[b] = evt_vec[b] | (flag_q[b] & ~status_rd);
			end
		end
	endgenerate

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			flag_q <= 16'h0000;
		else
			flag_q <= flag_d;
	end

	// Interrupt pin is active low and registered to keep it glitch free.
	// The price is one cycle of latency from flag to pin.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			o_irq_n <= 1'b1;
		else
			o_irq_n <= ~|(flag_q & enable);
	end

	// Mode outputs mirror the control word through their own flops.
	// A write reaches them one cycle after it lands in the register.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_tx_stream <= 1'b0;
			o_rx_stream <= 1'b0;
			o_cca_type  <= 2'h0;
			o_xcvr_seq  <= imx_pkg::SEQ_IDLE;
		end else begin
			o_tx_stream <= ctrl_q[imx_pkg::CTRL_TXSTRM];
			o_rx_stream <= ctrl_q[imx_pkg::CTRL_RXSTRM];
			o_cca_type  <= ctrl_q[imx_pkg::CTRL_TYPE_LO +: 2];
			o_xcvr_seq  <= ctrl_q[imx_pkg::CTRL_SEQ_LO +: 2];
		end
	end

	// Start pin history for its rising edge.
	// It resets low, the pin's idle level, so leaving reset gives no false edge.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			start_pin_q <= 1'b0;
		else
			start_pin_q <= i_seq_start_pin;
	end

	// One-cycle start of the selected sequence; idle never starts anything.
	// Timer mode ignores the pin, and manual mode ignores both comparator matches.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			o_seq_go <= 1'b0;
		else if (ctrl_q[1:0] == imx_pkg::SEQ_IDLE)
			o_seq_go <= 1'b0;
		else if (ctrl_q[imx_pkg::CTRL_TRIG])
			o_seq_go <= i_tc2_match | i_tc2p_match;
		else
			o_seq_go <= i_seq_start_pin & ~start_pin_q;
	end

	assign deep = mask_q[imx_pkg::MASK_DEEP];

	// Doze state: deep doze ignores the comparator so the timer can stop.
	// The primed comparator only starts sequences; it never ends a doze.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			doze_q <= imx_pkg::IMX_RUN;
		else begin
			unique case (doze_q)
				imx_pkg::IMX_RUN:
					if (i_doze_req)
						doze_q <= imx_pkg::IMX_DOZE;
				imx_pkg::IMX_DOZE:
					if (!i_wake_n || (!deep && i_tc2_match))
						doze_q <= imx_pkg::IMX_RUN;
			endcase
		end
	end

	// Timer and prescaler clocks stop only while dozing deeply.
	// The enable is registered, so the timers run one cycle into deep doze.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_dozing     <= 1'b0;
			o_tmr_clk_en <= 1'b1;
		end else begin
			o_dozing     <= doze_q == imx_pkg::IMX_DOZE;
			o_tmr_clk_en <= !(doze_q == imx_pkg::IMX_DOZE && deep);
		end
	end

	// Checks below tie outputs to their causes.

	irq_follows_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		|(flag_q & enable) |=> !o_irq_n)
		else $error("irq pin not asserted for enabled flag");

	irq_masked_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(flag_q & enable) == 16'h0000 |=> o_irq_n)
		else $error("irq pin asserted with no enabled flag");

	flag_sets_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		i_evt.attn |=> flag_q[15])
		else $error("event did not set its flag");

	read_clears_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		status_rd && evt_vec == 16'h0000 |=> flag_q == 16'h0000)
		else $error("status read did not clear flags");

	set_wins_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		status_rd && i_evt.pll_unlock |=> flag_q[9])
		else $error("event lost during clear");

	attn_default_a: assert property (@(posedge i_mclk)
		i_sys_rst |=> mask_q[imx_pkg::MASK_ATTN])
		else $error("attention enable not set after reset");

	deep_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		doze_q == imx_pkg::IMX_DOZE && deep && i_wake_n |=> doze_q == imx_pkg::IMX_DOZE)
		else $error("deep doze left without wake");

	deep_clk_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		doze_q == imx_pkg::IMX_DOZE && deep |=> !o_tmr_clk_en)
		else $error("timer clock running in deep doze");

	tc2_exit_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		doze_q == imx_pkg::IMX_DOZE && !deep && i_tc2_match |=> doze_q == imx_pkg::IMX_RUN ##1 !o_dozing)
		else $error("comparator match did not end doze");

	timed_start_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl_q[imx_pkg::CTRL_TRIG] && ctrl_q[1:0] != imx_pkg::SEQ_IDLE && i_tc2_match |=> o_seq_go)
		else $error("timer trigger did not start sequence");

	manual_start_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_seq_go && !$past(ctrl_q[imx_pkg::CTRL_TRIG]) |-> $past(i_seq_start_pin) && !$past(start_pin_q))
		else $error("manual start without pin edge");

	seq_out_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$changed(ctrl_q) |=> o_xcvr_seq == $past(ctrl_q[1:0]) && o_cca_type == $past(ctrl_q[5:4]))
		else $error("mode outputs do not follow control word");

	stream_out_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl_q[imx_pkg::CTRL_TXSTRM] ##1 ctrl_q[imx_pkg::CTRL_TXSTRM] |-> o_tx_stream)
		else $error("transmit stream select not forwarded");

	// Each enable is also checked on its own, the four compare enables as one group,
	// so a swapped field is reported by name rather than hidden behind the shared pin check.

	attn_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		flag_q[15] && mask_q[imx_pkg::MASK_ATTN] |=> !o_irq_n)
		else $error("attention enable ignored");

	ram_err_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		flag_q[12] && mask_q[imx_pkg::MASK_RAMAD] |=> !o_irq_n)
		else $error("address error enable ignored");

	arb_err_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		flag_q[11] && mask_q[imx_pkg::MASK_ARB] |=> !o_irq_n)
		else $error("arbiter busy enable ignored");

	strm_err_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		flag_q[10] && mask_q[imx_pkg::MASK_STRM] |=> !o_irq_n)
		else $error("stream data error enable ignored");

	lock_loss_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		flag_q[9] && mask_q[imx_pkg::MASK_PLL] |=> !o_irq_n)
		else $error("lock loss enable ignored");

	doze_flag_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		flag_q[4] && mask_q[imx_pkg::MASK_DOZE] |=> !o_irq_n)
		else $error("doze timer enable ignored");

	compare_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		|(flag_q[3:0] & mask_q[3:0]) |=> !o_irq_n)
		else $error("event compare enable ignored");

	cca_done_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		flag_q[14] && ctrl_q[imx_pkg::CTRL_CCA] |=> !o_irq_n)
		else $error("assessment done enable ignored");

	tx_sent_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		flag_q[13] && ctrl_q[imx_pkg::CTRL_TXSENT] |=> !o_irq_n)
		else $error("transmit sent enable ignored");

	rx_rcvd_irq_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		flag_q[8] && ctrl_q[imx_pkg::CTRL_RXRCVD] |=> !o_irq_n)
		else $error("packet received enable ignored");

	flag_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!status_rd |=> (flag_q & $past(flag_q)) == $past(flag_q))
		else $error("flag lost without a status read");

	// Mode, start and reset outputs; an idle sequence must stay quiet
	// whatever the trigger inputs do.

	rx_stream_out_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl_q[imx_pkg::CTRL_RXSTRM] ##1 ctrl_q[imx_pkg::CTRL_RXSTRM] |-> o_rx_stream)
		else $error("receive stream select not forwarded");

	primed_start_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl_q[imx_pkg::CTRL_TRIG] && ctrl_q[1:0] != imx_pkg::SEQ_IDLE && i_tc2p_match |=> o_seq_go)
		else $error("primed trigger did not start sequence");

	idle_no_go_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		ctrl_q[1:0] == imx_pkg::SEQ_IDLE |=> !o_seq_go)
		else $error("idle sequence started");

	reset_quiet_a: assert property (@(posedge i_mclk)
		i_sys_rst |=> o_irq_n && !o_seq_go && o_xcvr_seq == imx_pkg::SEQ_IDLE)
		else $error("outputs not quiet after reset");

	// Doze entry, exit and the outputs that report it; the primed match
	// must never end a doze on its own.

	dozing_out_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		doze_q == imx_pkg::IMX_DOZE |=> o_dozing)
		else $error("doze not reported");

	shallow_clk_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		doze_q == imx_pkg::IMX_DOZE && !deep |=> o_tmr_clk_en)
		else $error("timer clock stopped in shallow doze");

	wake_exit_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		doze_q == imx_pkg::IMX_DOZE && !i_wake_n |=> doze_q == imx_pkg::IMX_RUN)
		else $error("wake pin did not end doze");

	doze_stay_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		doze_q == imx_pkg::IMX_DOZE && i_wake_n && !i_tc2_match |=> doze_q == imx_pkg::IMX_DOZE)
		else $error("doze left without an exit cause");

	doze_entry_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		doze_q == imx_pkg::IMX_RUN && i_doze_req |=> doze_q == imx_pkg::IMX_DOZE)
		else $error("doze request ignored");

endmodule
`default_nettype wire

// ==== src/imx_pkg.sv ====
/*
 * Shared constants and carrier types for the interrupt mask and primary
 * transceiver control block. Assumes a single 250 MHz core clock and a host
 * that reaches the registers over the serial register port.
 */
package imx_pkg;

	// Register addresses on the serial port.
	localparam logic [5:0] ADDR_MASK   = 6'h05;
	localparam logic [5:0] ADDR_CTRL   = 6'h06;
	localparam logic [5:0] ADDR_STATUS = 6'h24;

	// Reset values and writable-bit masks; reserved bits read as zero.
	localparam logic [15:0] MASK_RST  = 16'h8000;
	localparam logic [15:0] MASK_WMSK = 16'h9F1F;
	localparam logic [15:0] CTRL_RST  = 16'h0000;
	localparam logic [15:0] CTRL_WMSK = 16'h1FB3;

	// Mask register field positions.
	localparam int MASK_ATTN  = 15;
	localparam int MASK_RAMAD = 12;
	localparam int MASK_ARB   = 11;
	localparam int MASK_STRM  = 10;
	localparam int MASK_PLL   = 9;
	localparam int MASK_DEEP  = 8;
	localparam int MASK_DOZE  = 4;

	// Control register field positions.
	localparam int CTRL_TXSTRM = 12;
	localparam int CTRL_RXSTRM = 11;
	localparam int CTRL_CCA    = 10;
	localparam int CTRL_TXSENT = 9;
	localparam int CTRL_RXRCVD = 8;
	localparam int CTRL_TRIG   = 7;
	localparam int CTRL_TYPE_LO = 4;
	localparam int CTRL_SEQ_LO = 0;

	// Sequence and assessment encodings.
	localparam logic [1:0] SEQ_IDLE = 2'h0;
	localparam logic [1:0] SEQ_CCA  = 2'h1;
	localparam logic [1:0] SEQ_RX   = 2'h2;
	localparam logic [1:0] SEQ_TX   = 2'h3;
	localparam logic [1:0] TYPE_CCA = 2'h1;
	localparam logic [1:0] TYPE_ED  = 2'h2;

	// Serial frame layout: header byte, then one data word.
	localparam logic [4:0] HDR_BITS   = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam int         HDR_RD_BIT = 7;

	// Event and status flags, one bit each, in status register order.
	typedef struct packed {
		logic       attn;
		logic       cca_done;
		logic       tx_sent;
		logic       ram_addr_err;
		logic       arb_busy_err;
		logic       strm_data_err;
		logic       pll_unlock;
		logic       rx_rcvd;
		logic [2:0] rsvd;
		logic       doze;
		logic [3:0] event_compare;
	} imx_evt_t;

	// One register access decoded from a serial frame.
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [5:0]  addr;
		logic [15:0] wdata;
	} imx_req_t;

	// Doze state of the device.
	typedef enum logic {
		IMX_RUN  = 1'b0,
		IMX_DOZE = 1'b1
	} imx_doze_t;

endpackage

// ==== src/imx_spi_port.sv ====
/*
 * Serial register port: turns one chip-enable frame into one register read
 * or write request. Assumes the serial clock is synchronous to i_mclk and
 * each serial half-period lasts at least three core clock cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module imx_spi_port (
	input  wire logic             i_mclk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_spi_ce_n,
	input  wire logic             i_spi_clk,
	input  wire logic             i_spi_mosi,
	input  wire logic [15:0]      i_rd_data,
	output imx_pkg::imx_req_t     o_req,
	output logic                  o_miso,
	output logic                  o_miso_oe_n
);
	logic             sclk_q;
	logic [4:0]       cnt_q;
	logic [15:0]      shin_q;
	logic [15:0]      shout_q;
	logic             rd_frame_q;
	imx_pkg::imx_req_t req_q;
	logic             rise;
	logic             fall;

	assign rise = i_spi_clk & ~sclk_q;
	assign fall = ~i_spi_clk & sclk_q;
	assign o_req = req_q;

	// Edge history of the serial clock.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			sclk_q <= 1'b0;
		else
			sclk_q <= i_spi_clk;
	end

	// Input shifter and bit counter; extra bits past the word are ignored.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || i_spi_ce_n) begin
			cnt_q  <= 5'h00;
			shin_q <= 16'h0000;
		end else if (rise && cnt_q < imx_pkg::FRAME_BITS) begin
			cnt_q  <= cnt_q + 5'h01;
			shin_q <= {shin_q[14:0], i_spi_mosi};
		end
	end

	// Requests are one-cycle pulses; a read fires after the header byte.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			req_q      <= '0;
			rd_frame_q <= 1'b0;
		end else begin
			req_q.rd <= 1'b0;
			req_q.wr <= 1'b0;
			if (!i_spi_ce_n && rise && cnt_q == imx_pkg::HDR_BITS - 5'h01) begin
				rd_frame_q <= shin_q[imx_pkg::HDR_RD_BIT - 1];
				req_q.addr <= {shin_q[4:0], i_spi_mosi};
				req_q.rd   <= shin_q[imx_pkg::HDR_RD_BIT - 1];
			end
			if (!i_spi_ce_n && rise && !rd_frame_q && cnt_q == imx_pkg::FRAME_BITS - 5'h01) begin
				req_q.wr    <= 1'b1;
				req_q.wdata <= {shin_q[14:0], i_spi_mosi};
			end
		end
	end

	// Output shifter: loads with the read word, then moves on falling edges.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || i_spi_ce_n) begin
			shout_q     <= 16'h0000;
			o_miso      <= 1'b0;
			o_miso_oe_n <= 1'b1;
		end else begin
			o_miso_oe_n <= 1'b0;
			if (req_q.rd) begin
				shout_q <= i_rd_data;
				o_miso  <= i_rd_data[15];
			end else if (fall && cnt_q > imx_pkg::HDR_BITS && cnt_q < imx_pkg::FRAME_BITS) begin
				shout_q <= {shout_q[14:0], 1'b0};
				o_miso  <= shout_q[14];
			end
		end
	end

endmodule
`default_nettype wire

// ==== tb/imx_host_model.sv ====
/*
 * Host model on the far side of the serial register port: sends one frame per
 * chip-enable period and hands back each read word with a one-cycle strobe.
 * Assumes i_mclk is the device core clock and the MISO wire level is resolved
 * by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module imx_host_model #(
	parameter int HP = 8
) (
	input  wire logic        i_mclk,
	input  wire logic        i_spi_miso,
	output var  logic        o_spi_ce_n,
	output var  logic        o_spi_clk,
	output var  logic        o_spi_mosi,
	output var  logic        o_rd_valid,
	output var  logic [15:0] o_rd_word
);
	// Idle levels; the serial clock rests low between frames.
	initial begin
		o_spi_ce_n = 1'b1;
		o_spi_clk  = 1'b0;
		o_spi_mosi = 1'b0;
		o_rd_valid = 1'b0;
		o_rd_word  = 16'h0000;
	end

	// Changes land just after a core clock edge, never on it.
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	// One access per chip-enable period, header then word, MSB first.
	// The half-period is well above the port's minimum so MISO is settled when sampled.
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [15:0] wd);
		logic [23:0] f;
		f = {rd, 1'b0, a, wd};
		tick(1);
		o_spi_ce_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			o_spi_mosi = f[i];
			tick(HP);
			if (i < 16) begin
				o_rd_word[i] = i_spi_miso;
			end
			o_spi_clk = 1'b1;
			tick(HP);
			o_spi_clk = 1'b0;
		end
		o_spi_mosi = ~f[0]; // A line past its hold time shows the inverse, not the last bit.
		tick(HP);
		o_spi_ce_n = 1'b1;
		tick(HP);
		if (rd) begin
			o_rd_valid = 1'b1;
			tick(1);
			o_rd_valid = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/*
 * Self-checking bench for the interrupt mask and control block: registers,
 * per-source interrupt gating, sequence start and doze.
 * Assumes the host model file is compiled before this one.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                clk;
	logic                rst;
	logic                ce_n;
	logic                sclk;
	logic                mosi;
	logic                miso;
	logic                miso_oe_n;
	logic                miso_w;
	imx_pkg::imx_evt_t   evt;
	logic                doze_req;
	logic                wake_n;
	logic                tc2;
	logic                tc2p;
	logic                start;
	logic                irq_n;
	logic                dozing;
	logic                tmr_en;
	logic                txs;
	logic                rxs;
	logic [1:0]          ctype;
	logic [1:0]          cseq;
	logic                go;
	logic                rd_valid;
	logic [15:0]         rd_word;
	logic [15:0]         exp_q[$];
	logic [15:0]         v;
	logic [31:0]         lfsr_s;
	int                  mismatches;
	int                  compares;
	int                  n;
	int                  src[13] = '{15, 14, 13, 12, 11, 10, 9, 8, 4, 3, 2, 1, 0};

	// A released MISO shows the inverse of its last level, so a stale bit never reads as good.
	assign miso_w = miso_oe_n ? ~miso : miso;

	imx_core dut (.i_mclk(clk), .i_sys_rst(rst), .i_spi_ce_n(ce_n), .i_spi_clk(sclk), .i_spi_mosi(mosi),
		.o_spi_miso(miso), .o_spi_miso_oe_n(miso_oe_n), .i_evt(evt), .i_doze_req(doze_req), .i_wake_n(wake_n),
		.i_tc2_match(tc2), .i_tc2p_match(tc2p), .i_seq_start_pin(start), .o_irq_n(irq_n), .o_dozing(dozing),
		.o_tmr_clk_en(tmr_en), .o_tx_stream(txs), .o_rx_stream(rxs), .o_cca_type(ctype), .o_xcvr_seq(cseq),
		.o_seq_go(go));
	imx_host_model #(.HP(8)) host (.i_mclk(clk), .i_spi_miso(miso_w), .o_spi_ce_n(ce_n), .o_spi_clk(sclk),
		.o_spi_mosi(mosi), .o_rd_valid(rd_valid), .o_rd_word(rd_word));

	// Core clock at 250 MHz.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host.xfer(1'b1, a, 16'h0000);
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		host.xfer(1'b0, a, d);
	endtask

	// A one-cycle comparator pulse; the primed one when p is set.
	task automatic pulse_tc(input logic p);
		tc2  = ~p;
		tc2p = p;
		step(1);
		tc2  = 1'b0;
		tc2p = 1'b0;
	endtask

	// Counts start pulses over a short window, so a doubled pulse is caught too.
	// The window opens on the edge that follows the trigger, where the pulse first stands.
	task automatic go_count(output int c);
		c = 0;
		repeat (5) begin
			if (go === 1'b1) c++;
			step(1);
		end
	endtask

	// Read words are compared in arrival order with the queued expectations.
	always @(posedge clk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() > 0) chk(rd_word, exp_q.pop_front());
		end
	end

	task automatic complete_run();
		if (mismatches == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run length.
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		complete_run();
	end

	initial begin
		rst = 1'b1;
		evt = '0;
		doze_req = 1'b0;
		wake_n = 1'b1;
		tc2 = 1'b0;
		tc2p = 1'b0;
		start = 1'b0;
		lfsr_s = 32'hF06B258C;
		mismatches = 0;
		compares = 0;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		chk({14'h0, irq_n, tmr_en}, 16'h3);
		rd(imx_pkg::ADDR_MASK, 16'h8000);
		rd(imx_pkg::ADDR_CTRL, 16'h0000);
		// Reserved positions must drop writes and read back zero.
		wr(imx_pkg::ADDR_MASK, 16'hFFFF);
		rd(imx_pkg::ADDR_MASK, 16'h9F1F);
		wr(imx_pkg::ADDR_CTRL, 16'hFFFF);
		rd(imx_pkg::ADDR_CTRL, 16'h1FB3);
		wr(6'h3F, 16'hFFFF);
		rd(6'h3F, 16'h0000);
		// Each source with only its own enable set, then with every enable clear.
		foreach (src[k]) begin
			for (int en = 1; en >= 0; en--) begin
				v = (src[k] == 14) ? 16'h0400 : (src[k] == 13) ? 16'h0200 : (src[k] == 8) ? 16'h0100 : 16'h0000;
				wr(imx_pkg::ADDR_MASK, (en == 1 && v == 16'h0000) ? (16'h1 << src[k]) : 16'h0000);
				wr(imx_pkg::ADDR_CTRL, (en == 1) ? v : 16'h0000);
				evt = imx_pkg::imx_evt_t'(16'h1 << src[k]);
				step(1);
				evt = '0;
				step(3);
				chk({15'h0, irq_n}, (en == 1) ? 16'h0 : 16'h1);
				rd(imx_pkg::ADDR_STATUS, 16'h1 << src[k]);
				step(2);
				chk({15'h0, irq_n}, 16'h1);
			end
		end
		// Random control words; every sequence and assessment code is visited.
		for (int i = 0; i < 8; i++) begin
			lfsr_s = lfsr(lfsr_s);
			v = lfsr_s[15:0] & imx_pkg::CTRL_WMSK;
			v[1:0] = i[1:0];
			v[5:4] = i[1:0];
			wr(imx_pkg::ADDR_CTRL, v);
			rd(imx_pkg::ADDR_CTRL, v);
			chk({10'h0, txs, rxs, ctype, cseq}, {10'h0, v[12], v[11], v[5:4], v[1:0]});
		end
		// Manual start versus timer start, and nothing from an idle sequence.
		wr(imx_pkg::ADDR_CTRL, 16'h0003);
		start = 1'b1;
		step(1);
		start = 1'b0;
		go_count(n);
		chk(16'(n), 16'h1);
		pulse_tc(1'b0);
		go_count(n);
		chk(16'(n), 16'h0);
		wr(imx_pkg::ADDR_CTRL, 16'h0082);
		pulse_tc(1'b0);
		go_count(n);
		chk(16'(n), 16'h1);
		pulse_tc(1'b1);
		go_count(n);
		chk(16'(n), 16'h1);
		wr(imx_pkg::ADDR_CTRL, 16'h0080);
		pulse_tc(1'b0);
		go_count(n);
		chk(16'(n), 16'h0);
		// Deep doze ignores the comparator and leaves only on the wake pin; shallow doze then ends on a comparator match.
		wr(imx_pkg::ADDR_MASK, 16'h8100);
		doze_req = 1'b1;
		step(1);
		doze_req = 1'b0;
		step(3);
		chk({14'h0, dozing, tmr_en}, 16'h2);
		pulse_tc(1'b0);
		step(3);
		chk({14'h0, dozing, tmr_en}, 16'h2);
		wake_n = 1'b0;
		step(2);
		wake_n = 1'b1;
		step(3);
		chk({14'h0, dozing, tmr_en}, 16'h1);
		wr(imx_pkg::ADDR_MASK, 16'h8000);
		doze_req = 1'b1;
		step(1);
		doze_req = 1'b0;
		step(3);
		chk({14'h0, dozing, tmr_en}, 16'h3);
		pulse_tc(1'b0);
		step(3);
		chk({14'h0, dozing, tmr_en}, 16'h1);
		// A second reset mid-run must bring every default back.
		wr(imx_pkg::ADDR_MASK, 16'h001F);
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		chk({14'h0, irq_n, tmr_en}, 16'h3);
		rd(imx_pkg::ADDR_MASK, imx_pkg::MASK_RST);
		rd(imx_pkg::ADDR_CTRL, imx_pkg::CTRL_RST);
		complete_run();
	end
endmodule
`default_nettype wire
